// >>> rtl/rcod_pkg.sv
`default_nettype none
package rcod_pkg;
    // register indices
    localparam logic [3:0] ADDR_CTRL_LOW = 4'h0;
    localparam logic [3:0] ADDR_CTRL_HIGH = 4'h1;
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h2;
    // low control register field positions
    localparam int BIT_ENABLE = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_PIN_DRIVE = 12;
    localparam int BIT_SLEEP_RUN = 11;
    localparam int BIT_SWITCH = 9;
    localparam int BIT_ACTIVE = 8;
    localparam logic [15:0] LOW_WRITE_MASK = 16'hb80f;
    localparam logic [15:0] HIGH_WRITE_MASK = 16'h7fff;
    // oscillator control register field positions
    localparam int BIT_OSC_MANUAL = 0;
    localparam int BIT_OSC_RUNNING = 1;
    localparam int BIT_OSC_PIN_SEL = 2;
    localparam int BIT_OSC_DRIVE = 3;
    // reset values
    localparam logic [15:0] RESET_CTRL_LOW = 16'h0000;
    localparam logic [14:0] RESET_DIVISOR = 15'h0000;
    // source selector codes
    typedef enum logic [3:0] {
        SRC_MAIN = 4'b0000,
        SRC_SYS_HALF = 4'b0001,
        SRC_PRIMARY = 4'b0010,
        SRC_FAST_RC = 4'b0011,
        SRC_LOW_POWER_RC = 4'b0100,
        SRC_LOW_SPEED = 4'b0101,
        SRC_PLL = 4'b0110,
        SRC_EXT_PIN = 4'b1000
    } rcod_src_t;
    localparam int NUM_SOURCES = 7;
    // low speed oscillator start-up times, in microseconds at 100 MHz
    // short values keep a start-up wait brief; a slow crystal needs them raised
    localparam int OSC_START_HIGH_US = 10;
    localparam int OSC_START_LOW_US = 20;
    localparam int CLK_MHZ = 100;
    localparam int OSC_START_HIGH_CYC = OSC_START_HIGH_US * CLK_MHZ;
    localparam int OSC_START_LOW_CYC = OSC_START_LOW_US * CLK_MHZ;
endpackage
`default_nettype wire

// >>> rtl/rcod_div_if.sv
`default_nettype none
// link between register core and divider
interface rcod_div_if;
    logic run;
    logic base_tick;
    logic base_level;
    logic [14:0] divisor;
    logic switch_req;
    logic switch_done;
    logic clk_out;
    modport core (output run, base_tick, base_level, divisor, switch_req, input switch_done, clk_out);
    modport div (input run, base_tick, base_level, divisor, switch_req, output switch_done, clk_out);
endinterface
`default_nettype wire

// >>> rtl/rcod_divider.sv
`default_nettype none
module rcod_divider (
    input wire logic i_clk,
    input wire logic i_rst,
    rcod_div_if.div bus
);
    import rcod_pkg::*;

    typedef struct packed {
        logic [14:0] active_div;
        logic [14:0] count;
        logic out;
        logic done;
    } rcod_div_state_t;

    rcod_div_state_t st_reg;
    rcod_div_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // half-period counter on base clock rising edges
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (!bus.run) begin
            st_next.out = 1'b0;
            st_next.count = 15'h0000;
            // idle divider takes a new divisor at once, nothing to glitch;
            // the request is still seen the cycle after done, so swap only once
            if (bus.switch_req && !st_reg.done) begin
                st_next.active_div = bus.divisor;
                st_next.done = 1'b1;
            end
        end else if (st_reg.active_div == 15'h0000) begin
            st_next.out = bus.base_level;
            if (bus.switch_req && bus.base_tick) begin
                st_next.active_div = bus.divisor;
                st_next.done = 1'b1;
            end
        end else if (bus.base_tick) begin
            if (st_reg.count + 15'h0001 >= st_reg.active_div) begin
                st_next.count = 15'h0000;
                st_next.out = ~st_reg.out;
                // swap only at end of a high half: low then high is one full period
                if (st_reg.out && bus.switch_req) begin
                    st_next.active_div = bus.divisor;
                    st_next.done = 1'b1;
                end
            end else begin
                st_next.count = st_reg.count + 15'h0001;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.clk_out = st_reg.out;
    assign bus.switch_done = st_reg.done;
endmodule
`default_nettype wire

// >>> rtl/rcod_refout.sv
`default_nettype none
// How it works
// - enable bit 15 of low control turns the generator on or off
// - idle-stop bit halts the generator while the device idles
// - pin-drive bit gates the divided clock onto the output pin
// - sleep-run bit keeps the generator running in sleep, else it stops
// - switch bit set by software, reads one until hardware finishes the swap
// - read-only active flag mirrors the enable bit, even while halted in idle or sleep; resets to zero
// - four-bit selector picks one of seven sources or the external pin
// - divisor gives the output half-period in base clock cycles
// - divisor zero passes the base clock through undivided
// - unimplemented bits ignore writes and read zero
// - a peripheral request starts the low speed oscillator automatically
// - manual-start bit starts the low speed oscillator ahead of demand
// - pin-select strap must be one, else oscillator pins are digital
// - drive-level strap picks high drive or slower low-power start
// - clearing enable clears active; disable only after active reads one
module rcod_refout (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [rcod_pkg::NUM_SOURCES-1:0] i_src_clk,
    input wire logic i_reference_input_pin,
    input wire logic i_idle_mode,
    input wire logic i_sleep_mode,
    input wire logic i_osc_periph_request,
    input wire logic i_osc_pin_select,
    input wire logic i_osc_drive_level,
    output logic o_osc_enable,
    output logic o_osc_ready,
    output logic o_osc_pins_digital,
    output logic o_reference_clock_pin,
    output logic o_reference_clock_pin_oe
);
    import rcod_pkg::*;

    typedef struct packed {
        logic enable;
        logic idle_stop;
        logic pin_drive;
        logic sleep_run;
        logic switch_busy;
        logic [3:0] source;
        logic [14:0] divisor;
        logic osc_manual;
        logic osc_pin_sel;
        logic osc_drive;
        logic strap_taken;
        logic [27:0] osc_timer;
        logic osc_ready;
        logic [NUM_SOURCES:0] sync1;
        logic [NUM_SOURCES:0] sync2;
        logic base_prev;
        logic pin_out;
        logic pin_oe;
        logic [15:0] rdata;
    } rcod_state_t;

    rcod_state_t st_reg;
    rcod_state_t st_next;
    rcod_div_if div_bus ();

    logic [NUM_SOURCES:0] raw_in;
    logic base_level;
    logic run;
    logic osc_on;
    logic [15:0] low_view;

    ////////////////////////////////////////////////////////////////////////////
    // source selection; every source is sampled on i_clk, so the highest usable
    // source rate is well under half of i_clk
    assign raw_in = {i_reference_input_pin, i_src_clk};

    always_comb begin
        case (rcod_src_t'(st_reg.source))
            SRC_MAIN: base_level = st_reg.sync2[0];
            SRC_SYS_HALF: base_level = st_reg.sync2[1];
            SRC_PRIMARY: base_level = st_reg.sync2[2];
            SRC_FAST_RC: base_level = st_reg.sync2[3];
            SRC_LOW_POWER_RC: base_level = st_reg.sync2[4];
            SRC_LOW_SPEED: base_level = st_reg.sync2[5] & st_reg.osc_ready & st_reg.osc_pin_sel;
            SRC_PLL: base_level = st_reg.sync2[6];
            SRC_EXT_PIN: base_level = st_reg.sync2[NUM_SOURCES];
            default: base_level = 1'b0; // reserved codes give no clock
        endcase
    end

    // generator runs when enabled and not halted by a power mode
    assign run = st_reg.enable
        && !(i_idle_mode && st_reg.idle_stop)
        && !(i_sleep_mode && !st_reg.sleep_run);

    // oscillator on by demand or manual start, only with pins assigned to it
    assign osc_on = st_reg.osc_pin_sel
        && (i_osc_periph_request
        || st_reg.osc_manual);

    assign low_view = {st_reg.enable, 1'b0, st_reg.idle_stop, st_reg.pin_drive, st_reg.sleep_run, 1'b0,
        st_reg.switch_busy, st_reg.enable, 4'h0, st_reg.source};

    assign div_bus.run = run;
    assign div_bus.base_level = base_level;
    assign div_bus.base_tick = base_level & ~st_reg.base_prev;
    assign div_bus.divisor = st_reg.divisor;
    assign div_bus.switch_req = st_reg.switch_busy;

    rcod_divider u_divider (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .bus(div_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state: registers, oscillator start-up, pin drive
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = raw_in;
        st_next.sync2 = st_reg.sync1;
        st_next.base_prev = base_level;
        // straps caught once after reset release
        if (!st_reg.strap_taken) begin
            st_next.strap_taken = 1'b1;
            st_next.osc_pin_sel = i_osc_pin_select;
            st_next.osc_drive = i_osc_drive_level;
        end
        // start-up wait; low drive level takes longer
        if (!osc_on) begin
            st_next.osc_timer = 28'h000_0000;
            st_next.osc_ready = 1'b0;
        end else if (!st_reg.osc_ready) begin
            if (st_reg.osc_timer >= (st_reg.osc_drive ? 28'(OSC_START_LOW_CYC) : 28'(OSC_START_HIGH_CYC))) begin
                st_next.osc_ready = 1'b1;
            end else begin
                st_next.osc_timer = st_reg.osc_timer + 28'h000_0001;
            end
        end
        // hardware clears the switch bit when the divider reports done
        if (div_bus.switch_done) begin
            st_next.switch_busy = 1'b0;
        end
        if (i_wr) begin
            if (i_addr == ADDR_CTRL_LOW) begin
                st_next.enable = i_wdata[BIT_ENABLE];
                st_next.idle_stop = i_wdata[BIT_IDLE_STOP];
                st_next.pin_drive = i_wdata[BIT_PIN_DRIVE];
                st_next.sleep_run = i_wdata[BIT_SLEEP_RUN];
                st_next.source = i_wdata[3:0];
                // only a one starts a switch; a set wins over the done clear
                if (i_wdata[BIT_SWITCH]) begin
                    st_next.switch_busy = 1'b1;
                end
            end else if (i_addr == ADDR_CTRL_HIGH) begin
                st_next.divisor = i_wdata[14:0];
            end else if (i_addr == ADDR_OSC_CTRL) begin
                st_next.osc_manual = i_wdata[BIT_OSC_MANUAL];
            end
        end
        // read data stand the cycle after the strobe only
        st_next.rdata = 16'h0000;
        if (i_rd) begin
            if (i_addr == ADDR_CTRL_LOW) begin
                st_next.rdata = low_view & (LOW_WRITE_MASK | 16'h0300);
            end else if (i_addr == ADDR_CTRL_HIGH) begin
                st_next.rdata = {1'b0, st_reg.divisor};
            end else if (i_addr == ADDR_OSC_CTRL) begin
                st_next.rdata = {12'h000, st_reg.osc_drive, st_reg.osc_pin_sel, st_reg.osc_ready,
                    st_reg.osc_manual};
            end else begin
                st_next.rdata = 16'h0000; // unmapped reads zero
            end
        end
        // registered pin: driven only when enabled for output
        st_next.pin_oe = st_reg.pin_drive & st_reg.enable;
        st_next.pin_out = st_reg.pin_drive & div_bus.clk_out;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rdata = st_reg.rdata;
    assign o_reference_clock_pin = st_reg.pin_out;
    assign o_reference_clock_pin_oe = st_reg.pin_oe;
    assign o_osc_enable = osc_on;
    assign o_osc_ready = st_reg.osc_ready;
    assign o_osc_pins_digital = ~st_reg.osc_pin_sel;
endmodule
`default_nettype wire

// >>> tb/rcod_refout_asserts.sv
`default_nettype none
module rcod_refout_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_idle_mode,
    input wire logic i_sleep_mode,
    input wire logic i_osc_periph_request,
    input wire logic i_osc_pin_select,
    input wire logic o_osc_enable,
    input wire logic o_osc_pins_digital,
    input wire logic o_reference_clock_pin,
    input wire logic o_reference_clock_pin_oe
);
    import rcod_pkg::*;
    logic [15:0] sh_reg;
    logic en;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // shadow of the low control word, so no internal probes are needed
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_reg <= 16'h0000;
        end else if (i_wr && i_addr == ADDR_CTRL_LOW) begin
            sh_reg <= i_wdata & LOW_WRITE_MASK;
        end
    end
    assign en = sh_reg[BIT_ENABLE];
    ////////////////////////////////////////
    a_active_view: assert property (i_rd && i_addr == ADDR_CTRL_LOW |=> o_rdata[BIT_ACTIVE] == $past(en))
        else $error("active flag differs from enable");
    a_low_unimpl: assert property (i_rd && i_addr == ADDR_CTRL_LOW |=> (o_rdata & 16'h44f0) == 16'h0000)
        else $error("unimplemented low bits not zero");
    a_high_unimpl: assert property (i_rd && i_addr == ADDR_CTRL_HIGH |=> !o_rdata[15])
        else $error("high word bit 15 not zero");
    a_pin_gate: assert property (i_wr && i_addr == ADDR_CTRL_LOW |-> ##2
        (o_reference_clock_pin_oe == (en && sh_reg[BIT_PIN_DRIVE])))
        else $error("pin enable does not follow pin drive and enable");
    a_off_quiet: assert property ((!en)[*8] |-> !o_reference_clock_pin && !o_reference_clock_pin_oe)
        else $error("output moves while disabled");
    a_idle_halt: assert property ((en && sh_reg[BIT_IDLE_STOP] && i_idle_mode)[*8] |-> !o_reference_clock_pin)
        else $error("output runs in idle with stop set");
    a_sleep_halt: assert property ((en && !sh_reg[BIT_SLEEP_RUN] && i_sleep_mode)[*8] |-> !o_reference_clock_pin)
        else $error("output runs in sleep without sleep run");
    a_osc_demand: assert property (i_osc_periph_request && i_osc_pin_select |-> o_osc_enable)
        else $error("peripheral request did not start oscillator");
    a_pins_digital: assert property (!$past(i_rst) |=> (o_osc_pins_digital != i_osc_pin_select))
        else $error("oscillator pin mode wrong");
    c_running: cover property (o_reference_clock_pin_oe && o_reference_clock_pin);
    c_idle: cover property (en && sh_reg[BIT_IDLE_STOP] && i_idle_mode);
    c_sleep: cover property (en && i_sleep_mode);
endmodule
bind rcod_refout rcod_refout_asserts u_rcod_refout_asserts (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_idle_mode, .i_sleep_mode, .i_osc_periph_request, .i_osc_pin_select, .o_osc_enable,
    .o_osc_pins_digital, .o_reference_clock_pin, .o_reference_clock_pin_oe);
`default_nettype wire

// >>> tb/rcod_ext_dev.sv
`default_nettype none
module rcod_ext_dev (
    input wire logic i_clk,
    input wire logic i_pin,
    input wire logic i_oe,
    input wire logic i_clr,
    output var int o_hi = 0,
    output var int o_lo = 0,
    output var int o_min = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last = 1'b0;
    logic skip = 1'b1;
    int run = 0;
    logic lvl;
    // an undriven pin is pulled low on the board
    assign lvl = i_oe & i_pin;
    // measure every phase; the first one after clear is partial, so the minimum skips it
    always @(posedge i_clk) begin
        last <= lvl;
        run <= (lvl !== last) ? 1 : run + 1;
        if (lvl !== last && last) o_hi <= run;
        if (lvl !== last && !last) o_lo <= run;
        if (i_clr) begin
            skip <= 1'b1;
            o_min <= 32'h7fff_ffff;
        end else if (lvl !== last) begin
            skip <= 1'b0;
            if (!skip && run < o_min) o_min <= run;
        end
    end
endmodule
`default_nettype wire

// >>> tb/rcod_refout_tb.sv
`default_nettype none
module rcod_refout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcod_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, idle = 1'b0, slp = 1'b0, req = 1'b0, ext = 1'b0, clr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, got;
    logic [6:0] src = 7'h00;
    logic pin, oe, osc_en;
    logic psel = 1'b1, drv = 1'b0, osc_rdy, pdig;
    logic [14:0] dv = 15'h0000;
    int cnt = 0, miscompares = 0, tests_run = 0, hi_len, lo_len, min_len;
    always #5 clk = ~clk;
    // each source toggles at its own rate so a wrong selection shows as a wrong period
    always @(posedge clk) begin
        cnt <= cnt + 1;
        ext <= 1'((cnt / 10) % 2);
        for (int k = 0; k < NUM_SOURCES; k++) src[k] <= 1'((cnt / (k + 2)) % 2);
    end
    rcod_refout u_rcod_refout (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_src_clk(src), .i_reference_input_pin(ext), .i_idle_mode(idle), .i_sleep_mode(slp),
        .i_osc_periph_request(req), .i_osc_pin_select(psel), .i_osc_drive_level(drv), .o_osc_enable(osc_en),
        .o_osc_ready(osc_rdy), .o_osc_pins_digital(pdig), .o_reference_clock_pin(pin),
        .o_reference_clock_pin_oe(oe));
    rcod_ext_dev u_rcod_ext_dev (.i_clk(clk), .i_pin(pin), .i_oe(oe), .i_clr(clr), .o_hi(hi_len), .o_lo(lo_len),
        .o_min(min_len));
    ////////////////////////////////////////
    function automatic int half_len(logic [3:0] code, logic [14:0] d);
        int h;
        h = (code == 4'h8) ? 10 : int'(code) + 2;
        return (d == 15'h0000) ? h : 2 * h * int'(d);
    endfunction
    task automatic chk(logic [15:0] g, logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // settings only change while stopped, so every new setting goes through a disable
    task automatic ctl(logic [15:0] v);
        wreg(ADDR_CTRL_LOW, 16'h0000);
        wreg(ADDR_CTRL_LOW, v);
    endtask
    task automatic wait_sw();
        got = 16'h0200;
        for (int n = 0; n < 200 && got[BIT_SWITCH] !== 1'b0; n++) rreg(ADDR_CTRL_LOW, got);
        chk(16'(got[BIT_SWITCH]), 16'h0000);
    endtask
    task automatic run_src(logic [3:0] code, logic [14:0] d);
        dv = d;
        ctl({12'h000, code});
        wreg(ADDR_CTRL_HIGH, {1'b0, d});
        wreg(ADDR_CTRL_LOW, {12'h020, code});
        wait_sw();
        wreg(ADDR_CTRL_LOW, {12'h900, code});
        repeat (8 * half_len(code, d) + 20) @(posedge clk);
        chk(16'(hi_len), 16'(half_len(code, d)));
        chk(16'(lo_len), 16'(half_len(code, d)));
    endtask
    task automatic end_sim();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog sized well above the whole sequence
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(65));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rreg(ADDR_CTRL_LOW, got);
        chk(got, RESET_CTRL_LOW);
        wreg(ADDR_CTRL_HIGH, 16'hffff);
        rreg(ADDR_CTRL_HIGH, got);
        chk(got, 16'h7fff);
        wreg(ADDR_CTRL_LOW, 16'hf5ff);
        rreg(ADDR_CTRL_LOW, got);
        chk(got, 16'hb10f);
        wreg(4'h7, 16'hffff);
        rreg(4'h7, got);
        chk(got, 16'h0000);
        chk(16'(pin), 16'h0000);
        // low speed source needs its oscillator settled before the source sweep
        wreg(ADDR_OSC_CTRL, 16'h0001);
        repeat (OSC_START_HIGH_CYC - 5) @(posedge clk);
        #1 chk(16'(osc_rdy), 16'h0000);
        repeat (10) @(posedge clk);
        #1 chk(16'(osc_rdy), 16'h0001);
        chk(16'(pdig), 16'h0000);
        for (int i = 0; i < 8; i++) run_src((i == 7) ? 4'h8 : 4'(i), 15'((i == 1) ? 0 : $urandom_range(1, 3)));
        ctl(16'hb008);
        idle <= 1'b1;
        repeat (40) @(posedge clk);
        chk(16'(pin), 16'h0000);
        idle <= 1'b0;
        slp <= 1'b1;
        ctl(16'h9808);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (300) @(posedge clk);
        chk(16'(min_len), 16'(half_len(4'h8, dv)));
        slp <= 1'b0;
        run_src(4'h0, 15'h0001);
        // new divisor written while stopped, adopted by a switch while running
        wreg(ADDR_CTRL_LOW, 16'h0000);
        wreg(ADDR_CTRL_HIGH, 16'h0003);
        wreg(ADDR_CTRL_LOW, 16'h9000);
        clr <= 1'b1;
        wreg(ADDR_CTRL_LOW, 16'h9200);
        clr <= 1'b0;
        wait_sw();
        repeat (100) @(posedge clk);
        chk(16'(min_len), 16'h0004);
        chk(16'(hi_len), 16'h000c);
        wreg(ADDR_CTRL_LOW, 16'h0000);
        rreg(ADDR_CTRL_LOW, got);
        chk(got, 16'h0000);
        wreg(ADDR_OSC_CTRL, 16'h0001);
        rreg(ADDR_OSC_CTRL, got);
        chk(got & 16'h0005, 16'h0005);
        chk(16'(osc_en), 16'h0001);
        wreg(ADDR_OSC_CTRL, 16'h0000);
        req <= 1'b1;
        @(posedge clk);
        #1 chk(16'(osc_en), 16'h0001);
        repeat (20) @(posedge clk) req <= 1'($urandom_range(0, 1));
        @(posedge clk);
        // second reset with the other strap values: pins go digital, drive level is caught
        req <= 1'b0;
        psel <= 1'b0;
        drv <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wreg(ADDR_OSC_CTRL, 16'h0001);
        rreg(ADDR_OSC_CTRL, got);
        chk(got, 16'h0009);
        chk(16'(osc_en), 16'h0000);
        chk(16'(pdig), 16'h0001);
        end_sim();
    end
endmodule
`default_nettype wire
